// file: rtl/qpio_pkg.sv
// package: register offsets, reset values, bit positions and carrier structs for the ports
package qpio_pkg;
  localparam logic [7:0] QPIO_ADDR_PORT0 = 8'h80;
  localparam logic [7:0] QPIO_ADDR_PORT1 = 8'h90;
  localparam logic [7:0] QPIO_ADDR_PORT2 = 8'hA0;
  localparam logic [7:0] QPIO_ADDR_PORT3 = 8'hB0;
  localparam logic [7:0] QPIO_RST_ONES   = 8'hFF;
  localparam logic [7:0] QPIO_ALL_ONES   = 8'hFF;
  localparam logic [7:0] QPIO_ALL_ZERO   = 8'h00;
  // port 2 alternate bit positions
  localparam int QPIO_P2_SCLK   = 0;
  localparam int QPIO_P2_MOSI   = 1;
  localparam int QPIO_P2_MISO   = 2;
  localparam int QPIO_P2_SS     = 3;
  localparam int QPIO_P2_TIMER2_EXTERNAL_CONTROL   = 4;
  localparam int QPIO_P2_PWMA   = 5;
  localparam int QPIO_P2_PWMB   = 6;
  localparam int QPIO_P2_PWM_ALT_CLOCK_IN = 7;

  // core-side register access; one strobe per kind
  typedef struct packed {
    logic       wr_latch;
    logic       rd_latch;
    logic       rd_pin;
    logic       bit_op;
    logic [2:0] bit_sel;
    logic       bit_val;
    logic [7:0] addr;
    logic [7:0] wdata;
  } qpio_req_s;

  // pin-facing outputs for one port
  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
  } qpio_pad_s;

  // external memory cycle from the core
  typedef struct packed {
    logic        active;
    logic        data_phase;
    logic        data_drive;
    logic [23:0] addr;
    logic [7:0]  wdata;
  } qpio_xmem_s;
endpackage : qpio_pkg

// file: rtl/qpio_ports.sv
// four 8-bit parallel ports: latches, read paths, pin drivers and alternate functions
module qpio_ports
  import qpio_pkg::*;
(
  input  wire logic              clk_sys_i,
  input  wire logic              rst_i,
  input  wire qpio_pkg::qpio_req_s  req_i,
  output logic [7:0]             rdata_o,
  output logic                   rvalid_o,
  input  wire qpio_pkg::qpio_xmem_s xmem_i,
  output logic [7:0]             xmem_rdata_o,
  input  wire logic [7:0]        p0_pin_i,
  input  wire logic [7:0]        p1_pin_i,
  input  wire logic [7:0]        p2_pin_i,
  input  wire logic [7:0]        p3_pin_i,
  output qpio_pkg::qpio_pad_s    p0_pad_o,
  output qpio_pkg::qpio_pad_s    p2_pad_o,
  output qpio_pkg::qpio_pad_s    p3_pad_o,
  output logic [7:0]             p1_analog_sel_o,
  output logic [7:0]             p1_digital_o,
  input  wire logic              spi_en_i,
  input  wire logic              spi_sclk_i,
  input  wire logic              spi_mosi_i,
  output logic                   spi_miso_o,
  output logic                   spi_ss_o,
  output logic                   timer_c_clock_input_o,
  output logic                   timer2_external_control_o,
  input  wire logic              pwm_en_i,
  input  wire logic              pwm_output_a_i,
  input  wire logic              pwm_output_b_i,
  output logic                   pwm_alt_clock_in_o,
  input  wire logic              uart_tx_i,
  output logic                   uart_rx_o,
  output logic                   external_interrupt_a_o,
  output logic                   external_interrupt_b_o,
  output logic                   timer_a_count_input_o,
  output logic                   timer_b_count_input_o,
  input  wire logic              xmem_wr_strobe_i,
  input  wire logic              xmem_rd_strobe_i
);
  import qpio_pkg::*;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // byte rewritten with one bit replaced, for single-bit instructions
  function automatic logic [7:0] qpio_set_bit(input logic [7:0] b, input logic [2:0] s,
                                              input logic v);
    logic [7:0] r;
    r    = b;
    r[s] = v;
    return r;
  endfunction

  function automatic logic qpio_hit(input qpio_req_s r, input logic [7:0] a);
    return r.addr == a;
  endfunction

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [7:0] p0_s1_q, p0_s2_q;
  logic [7:0] p1_s1_q, p1_s2_q;
  logic [7:0] p2_s1_q, p2_s2_q;
  logic [7:0] p3_s1_q, p3_s2_q;

  // two stages each; only the second stage is read downstream
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      p0_s1_q <= QPIO_ALL_ONES;
      p0_s2_q <= QPIO_ALL_ONES;
      p1_s1_q <= QPIO_ALL_ZERO;
      p1_s2_q <= QPIO_ALL_ZERO;
      p2_s1_q <= QPIO_ALL_ONES;
      p2_s2_q <= QPIO_ALL_ONES;
      p3_s1_q <= QPIO_ALL_ONES;
      p3_s2_q <= QPIO_ALL_ONES;
    end
    else
    begin
      p0_s1_q <= p0_pin_i;
      p0_s2_q <= p0_s1_q;
      p1_s1_q <= p1_pin_i;
      p1_s2_q <= p1_s1_q;
      p2_s1_q <= p2_pin_i;
      p2_s2_q <= p2_s1_q;
      p3_s1_q <= p3_pin_i;
      p3_s2_q <= p3_s1_q;
    end
  end

  // ----------------------------------------------------------------
  // port latches
  // ----------------------------------------------------------------
  logic [7:0] p0_q, p1_q, p2_q, p3_q;
  logic [7:0] p0_d, p1_d, p2_d, p3_d;

  // a bit op merges into the stored latch byte, never the pin value
  always_comb
  begin
    p0_d = p0_q;
    p1_d = p1_q;
    p2_d = p2_q;
    p3_d = p3_q;
    if (req_i.wr_latch)
    begin
      if (qpio_hit(req_i, QPIO_ADDR_PORT0))
        p0_d = req_i.bit_op ? qpio_set_bit(p0_q, req_i.bit_sel, req_i.bit_val)
                            : req_i.wdata;
      if (qpio_hit(req_i, QPIO_ADDR_PORT1))
        p1_d = req_i.bit_op ? qpio_set_bit(p1_q, req_i.bit_sel, req_i.bit_val)
                            : req_i.wdata;
      if (qpio_hit(req_i, QPIO_ADDR_PORT2))
        p2_d = req_i.bit_op ? qpio_set_bit(p2_q, req_i.bit_sel, req_i.bit_val)
                            : req_i.wdata;
      if (qpio_hit(req_i, QPIO_ADDR_PORT3))
        p3_d = req_i.bit_op ? qpio_set_bit(p3_q, req_i.bit_sel, req_i.bit_val)
                            : req_i.wdata;
    end
    // external cycle wins over a core write so the bus never sees a low latch
    if (xmem_i.active)
      p0_d = QPIO_ALL_ONES;
  end

  // latch state; port 1 ones mean analog at power-on
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      p0_q <= QPIO_RST_ONES;
      p1_q <= QPIO_RST_ONES;
      p2_q <= QPIO_RST_ONES;
      p3_q <= QPIO_RST_ONES;
    end
    else
    begin
      p0_q <= p0_d;
      p1_q <= p1_d;
      p2_q <= p2_d;
      p3_q <= p3_d;
    end
  end

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  // rmw instructions must strobe rd_latch; rd_pin gives synchronised pins
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      rdata_o  <= QPIO_ALL_ZERO;
      rvalid_o <= 1'b0;
    end
    else
    begin
      rvalid_o <= req_i.rd_latch | req_i.rd_pin;
      rdata_o  <= QPIO_ALL_ZERO;
      if (req_i.rd_latch)
      begin
        case (req_i.addr)
          QPIO_ADDR_PORT0: rdata_o <= p0_q;
          QPIO_ADDR_PORT1: rdata_o <= p1_q;
          QPIO_ADDR_PORT2: rdata_o <= p2_q;
          QPIO_ADDR_PORT3: rdata_o <= p3_q;
          default:         rdata_o <= QPIO_ALL_ZERO;
        endcase
      end
      else if (req_i.rd_pin)
      begin
        case (req_i.addr)
          QPIO_ADDR_PORT0: rdata_o <= p0_s2_q;
          QPIO_ADDR_PORT1: rdata_o <= p1_s2_q;
          QPIO_ADDR_PORT2: rdata_o <= p2_s2_q;
          QPIO_ADDR_PORT3: rdata_o <= p3_s2_q;
          default:         rdata_o <= QPIO_ALL_ZERO;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // pin drivers
  // ----------------------------------------------------------------
  logic [7:0] p2_src, p3_src;

  // alternate sources; idle port 3 outputs sit high so the latch alone decides; enabled port 2 alternates replace the latch bit
  always_comb
  begin
    p2_src                 = p2_q;
    p3_src                 = QPIO_ALL_ONES;
    if (spi_en_i)
    begin
      p2_src[QPIO_P2_SCLK] = spi_sclk_i;
      p2_src[QPIO_P2_MOSI] = spi_mosi_i;
      p2_src[QPIO_P2_MISO] = 1'b1;
      p2_src[QPIO_P2_SS]   = 1'b1;
    end
    if (pwm_en_i)
    begin
      p2_src[QPIO_P2_PWMA] = pwm_output_a_i;
      p2_src[QPIO_P2_PWMB] = pwm_output_b_i;
    end
    p3_src[1]              = uart_tx_i;
    p3_src[6]              = xmem_wr_strobe_i;
    p3_src[7]              = xmem_rd_strobe_i;
  end

  // registered drivers; pull-up pins are modelled as drive-low only
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      p0_pad_o        <= '0;
      p2_pad_o        <= '{out: QPIO_ALL_ONES, oe: QPIO_ALL_ZERO};
      p3_pad_o        <= '{out: QPIO_ALL_ONES, oe: QPIO_ALL_ZERO};
      p1_analog_sel_o <= QPIO_RST_ONES;
      p1_digital_o    <= QPIO_ALL_ZERO;
      xmem_rdata_o    <= QPIO_ALL_ZERO;
    end
    else
    begin
      if (xmem_i.active)
      begin
        // push-pull from the multiplexed bus, no external pull-ups needed
        p0_pad_o.out <= xmem_i.data_phase ? xmem_i.wdata : xmem_i.addr[7:0];
        p0_pad_o.oe  <= (xmem_i.data_phase && !xmem_i.data_drive) ? QPIO_ALL_ZERO
                                                                   : QPIO_ALL_ONES;
        p2_pad_o.out <= xmem_i.data_phase ? xmem_i.addr[23:16] : xmem_i.addr[15:8];
        p2_pad_o.oe  <= QPIO_ALL_ONES;
      end
      else
      begin
        p0_pad_o.out <= QPIO_ALL_ZERO;
        p0_pad_o.oe  <= ~p0_q;
        p2_pad_o.out <= QPIO_ALL_ZERO;
        p2_pad_o.oe  <= ~p2_src;
      end
      p3_pad_o.out    <= QPIO_ALL_ZERO;
      p3_pad_o.oe     <= ~(p3_q & p3_src);
      // port 1 never drives; latch picks analog or digital per bit
      p1_analog_sel_o <= p1_q;
      p1_digital_o    <= p1_s2_q & ~p1_q;
      xmem_rdata_o    <= p0_s2_q;
    end
  end

  // ----------------------------------------------------------------
  // alternate inputs
  // ----------------------------------------------------------------
  // port 3 inputs see the pin only while the latch is one, otherwise a forced zero; port 2 inputs take the pin ungated
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      spi_miso_o                <= 1'b1;
      spi_ss_o                  <= 1'b1;
      timer_c_clock_input_o     <= 1'b1;
      timer2_external_control_o <= 1'b1;
      pwm_alt_clock_in_o        <= 1'b1;
      uart_rx_o                 <= 1'b1;
      external_interrupt_a_o    <= 1'b1;
      external_interrupt_b_o    <= 1'b1;
      timer_a_count_input_o     <= 1'b1;
      timer_b_count_input_o     <= 1'b1;
    end
    else
    begin
      spi_miso_o                <= p2_s2_q[QPIO_P2_MISO];
      spi_ss_o                  <= p2_s2_q[QPIO_P2_SS];
      timer_c_clock_input_o     <= p2_s2_q[QPIO_P2_SS];
      timer2_external_control_o <= p2_s2_q[QPIO_P2_TIMER2_EXTERNAL_CONTROL];
      pwm_alt_clock_in_o        <= p2_s2_q[QPIO_P2_PWM_ALT_CLOCK_IN];
      uart_rx_o                 <= p3_s2_q[0] & p3_q[0];
      external_interrupt_a_o    <= p3_s2_q[2] & p3_q[2];
      external_interrupt_b_o    <= p3_s2_q[3] & p3_q[3];
      timer_a_count_input_o     <= p3_s2_q[4] & p3_q[4];
      timer_b_count_input_o     <= p3_s2_q[5] & p3_q[5];
    end
  end
endmodule // qpio_ports

// file: testbench/qpio_ports_monitor.sv
// checker: read, latch-to-pad and external-cycle timing of the ports
module qpio_ports_monitor
  import qpio_pkg::*;
(
  input wire logic                 clk_sys_i,
  input wire logic                 rst_i,
  input wire qpio_pkg::qpio_req_s  req_i,
  input wire logic                 rvalid_o,
  input wire qpio_pkg::qpio_xmem_s xmem_i,
  input wire qpio_pkg::qpio_pad_s  p0_pad_o,
  input wire qpio_pkg::qpio_pad_s  p2_pad_o,
  input wire qpio_pkg::qpio_pad_s  p3_pad_o,
  input wire logic [7:0]           p1_analog_sel_o,
  input wire logic                 spi_en_i,
  input wire logic                 pwm_en_i,
  input wire logic                 pwm_output_a_i
);
  // ---
  // properties
  // ---
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (rst_i);
  logic rd;
  // either strobe counts as a read
  assign rd = req_i.rd_latch | req_i.rd_pin;
  // byte write then a quiet cycle, so the pad two edges on has settled
  sequence s_wr(a);
    req_i.wr_latch && !req_i.bit_op && req_i.addr == a && !xmem_i.active ##1
      !(req_i.wr_latch && req_i.addr == a) && !xmem_i.active;
  endsequence
  a_read_answer: assert property (rd |=> rvalid_o)
    else $error("read not answered in one cycle");
  a_valid_cause: assert property (rvalid_o |-> $past(rd))
    else $error("read valid without a read");
  a_p0_drain: assert property (s_wr(QPIO_ADDR_PORT0) |=>
    p0_pad_o == {8'h00, ~$past(req_i.wdata, 2)}) else $error("port 0 pad wrong");
  a_p1_select: assert property (s_wr(QPIO_ADDR_PORT1) |=>
    p1_analog_sel_o == $past(req_i.wdata, 2)) else $error("port 1 select wrong");
  a_p2_pullup: assert property (s_wr(QPIO_ADDR_PORT2) ##0 !(pwm_en_i | spi_en_i) |=>
    p2_pad_o.oe == ~$past(req_i.wdata, 2) && (p2_pad_o.out & p2_pad_o.oe) == 8'h00)
    else $error("port 2 pad wrong");
  a_p3_gate: assert property (s_wr(QPIO_ADDR_PORT3) |=>
    ((p3_pad_o.oe & ~p3_pad_o.out) | $past(req_i.wdata, 2)) == 8'hFF)
    else $error("port 3 zero bit not low");
  a_xmem_ones: assert property (xmem_i.active ##1
    !xmem_i.active && !(req_i.wr_latch && req_i.addr == QPIO_ADDR_PORT0)
    |=> p0_pad_o.oe == 8'h00) else $error("port 0 latch not ones after access");
  a_xmem_addr: assert property (xmem_i.active && !xmem_i.data_phase |=>
    p0_pad_o == {$past(xmem_i.addr[7:0]), 8'hFF} &&
    p2_pad_o == {$past(xmem_i.addr[15:8]), 8'hFF}) else $error("address pads wrong");
  a_xmem_data: assert property (xmem_i.active && xmem_i.data_phase &&
    xmem_i.data_drive |=>
    p0_pad_o == {$past(xmem_i.wdata), 8'hFF} && p2_pad_o.out == $past(xmem_i.addr[23:16]))
    else $error("data phase pads wrong");
  a_pwm_over: assert property (pwm_en_i && !xmem_i.active |=>
    (p2_pad_o.out[5] | !p2_pad_o.oe[5]) == $past(pwm_output_a_i)) else $error("pwm not on pin");
  a_reset_vals: assert property (disable iff (1'b0) rst_i |=>
    {p0_pad_o.oe, p2_pad_o.oe, p3_pad_o.oe, p1_analog_sel_o} == 32'h0000_00FF)
    else $error("reset values wrong");
endmodule // qpio_ports_monitor

bind qpio_ports qpio_ports_monitor mon_u (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .req_i(req_i),
  .rvalid_o(rvalid_o), .xmem_i(xmem_i), .p0_pad_o(p0_pad_o), .p2_pad_o(p2_pad_o),
  .p3_pad_o(p3_pad_o), .p1_analog_sel_o(p1_analog_sel_o), .spi_en_i(spi_en_i),
  .pwm_en_i(pwm_en_i), .pwm_output_a_i(pwm_output_a_i));

// file: testbench/qpio_pin_model.sv
// pin-side model: pull-ups and outside drivers on the port pins
module qpio_pin_model
  import qpio_pkg::*;
(
  input  wire qpio_pkg::qpio_pad_s p0_pad_i,
  input  wire qpio_pkg::qpio_pad_s p2_pad_i,
  input  wire qpio_pkg::qpio_pad_s p3_pad_i,
  input  wire logic [7:0]          ext_en_i,
  input  wire logic [7:0]          ext_val_i,
  output logic [7:0]               p0_pin_o,
  output logic [7:0]               p1_pin_o,
  output logic [7:0]               p2_pin_o,
  output logic [7:0]               p3_pin_o
);
  // ---
  // pin levels
  // ---
  // released pins sit at the pull-up unless pulled; a real clash goes unknown
  function automatic logic [7:0] lvl(qpio_pkg::qpio_pad_s p, logic [7:0] en, logic [7:0] v);
    lvl = ((p.oe & p.out) | (~p.oe & (~en | v))) ^ (p.oe & en & (p.out ^ v) & 8'hxx);
  endfunction
  // port 0 relies on outside pull-ups, ports 2 and 3 on inside ones
  assign p0_pin_o = lvl(p0_pad_i, ext_en_i, ext_val_i);
  assign p1_pin_o = ext_val_i;
  assign p2_pin_o = lvl(p2_pad_i, ext_en_i, ext_val_i);
  assign p3_pin_o = lvl(p3_pad_i, ext_en_i, ext_val_i);
endmodule // qpio_pin_model

// file: testbench/quad_parallel_io_ports_tb.sv
// self-checking bench for the four parallel ports
module quad_parallel_io_ports_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import qpio_pkg::*;
  typedef struct packed {logic [1:0] k; logic [7:0] a, d, ext, exp;} qpio_row_s;
  logic       clk_sys_i = 1'b0;
  logic       rst_i = 1'b1;
  logic       spi_en = 1'b0, pwm_en = 1'b0, pwm_a = 1'b0, pwm_b = 1'b0, rvalid_o, miso;
  logic [4:0] alt = '1;
  logic [7:0] ext_en = '0, ext_val = '0, rdata_o, xmem_rdata_o, p1_dig;
  logic [7:0] p0_pin, p1_pin, p2_pin, p3_pin;
  qpio_req_s  req = '0;
  qpio_xmem_s xm = '0;
  qpio_pad_s  p0_pad, p2_pad, p3_pad;
  int         n_errors = 0, checks = 0;
  // kind (0 write, 1 read latch, 2 read pin, 3 bit op), addr, data, outside drive, expected
  qpio_row_s rows [19] = '{
    {2'd1, 8'h80, 8'h00, 8'h00, 8'hFF}, {2'd1, 8'h90, 8'h00, 8'h00, 8'hFF},
    {2'd1, 8'hA0, 8'h00, 8'h00, 8'hFF}, {2'd1, 8'hB0, 8'h00, 8'h00, 8'hFF},
    {2'd0, 8'h80, 8'hA5, 8'h00, 8'h00}, {2'd1, 8'h80, 8'h00, 8'h00, 8'hA5},
    {2'd2, 8'h80, 8'h00, 8'h00, 8'hA5}, {2'd0, 8'h90, 8'h3C, 8'h00, 8'h00},
    {2'd1, 8'h90, 8'h00, 8'h00, 8'h3C}, {2'd0, 8'hA0, 8'h5A, 8'h00, 8'h00},
    {2'd1, 8'hA0, 8'h00, 8'h00, 8'h5A}, {2'd2, 8'hA0, 8'h00, 8'hFF, 8'h00},
    {2'd1, 8'hA0, 8'h00, 8'hFF, 8'h5A}, {2'd0, 8'hB0, 8'hC3, 8'h00, 8'h00},
    {2'd3, 8'hB0, 8'h0A, 8'h00, 8'h00}, {2'd3, 8'hB0, 8'h07, 8'h00, 8'h00},
    {2'd1, 8'hB0, 8'h00, 8'h00, 8'h47}, {2'd0, 8'hC0, 8'h55, 8'h00, 8'h00},
    {2'd1, 8'hC0, 8'h00, 8'h00, 8'h00}};

  // ---
  // design, pins and helpers
  // ---
  qpio_ports dut_u (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .req_i(req), .rdata_o(rdata_o),
    .rvalid_o(rvalid_o), .xmem_i(xm), .xmem_rdata_o(xmem_rdata_o), .p0_pin_i(p0_pin),
    .p1_pin_i(p1_pin), .p2_pin_i(p2_pin), .p3_pin_i(p3_pin), .p0_pad_o(p0_pad),
    .p2_pad_o(p2_pad), .p3_pad_o(p3_pad), .p1_analog_sel_o(), .p1_digital_o(p1_dig),
    .spi_en_i(spi_en), .spi_sclk_i(alt[0]), .spi_mosi_i(alt[1]), .spi_miso_o(miso), .spi_ss_o(),
    .timer_c_clock_input_o(), .timer2_external_control_o(), .pwm_en_i(pwm_en),
    .pwm_output_a_i(pwm_a), .pwm_output_b_i(pwm_b), .pwm_alt_clock_in_o(),
    .uart_tx_i(alt[2]), .uart_rx_o(), .external_interrupt_a_o(), .external_interrupt_b_o(),
    .timer_a_count_input_o(), .timer_b_count_input_o(), .xmem_wr_strobe_i(alt[3]),
    .xmem_rd_strobe_i(alt[4]));
  qpio_pin_model pins_u (.p0_pad_i(p0_pad), .p2_pad_i(p2_pad), .p3_pad_i(p3_pad),
    .ext_en_i(ext_en), .ext_val_i(ext_val), .p0_pin_o(p0_pin), .p1_pin_o(p1_pin),
    .p2_pin_o(p2_pin), .p3_pin_o(p3_pin));
  // one core request from a row kind; bit ops carry select in d[2:0], value in d[3]
  function automatic qpio_req_s mk(logic [1:0] k, logic [7:0] a, logic [7:0] d);
    mk = '0;
    mk.wr_latch = (k == 2'd0) || (k == 2'd3);
    mk.rd_latch = (k == 2'd1);
    mk.rd_pin = (k == 2'd2);
    mk.bit_op = (k == 2'd3);
    mk.bit_sel = d[2:0];
    mk.bit_val = d[3];
    mk.addr = a;
    mk.wdata = d;
  endfunction
  // compare one byte and keep the tallies
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one-cycle request; a read is answered exactly one edge later
  task automatic op(input qpio_req_s r, input logic [7:0] exp);
    @(negedge clk_sys_i);
    req = r;
    @(negedge clk_sys_i);
    req = '0;
    if (r.rd_latch || r.rd_pin)
    begin
      chk({7'h00, rvalid_o}, 8'h01);
      chk(rdata_o, exp);
    end
  endtask
  // counts, verdict and end of run
  task automatic give_verdict();
    $display("checks=%0d n_errors=%0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // ---
  // stimulus
  // ---
  // 125 MHz clock
  initial
  begin
    forever #4 clk_sys_i = ~clk_sys_i;
  end
  // hang guard: the sequence needs about 135 cycles
  initial
  begin
    repeat (4000) @(posedge clk_sys_i);
    n_errors++;
    give_verdict();
  end
  // table first, then external cycle, port 1 input, pwm, spi and a second reset
  initial
  begin
    repeat (5) @(negedge clk_sys_i);
    rst_i = 1'b0;
    foreach (rows[i])
    begin
      ext_en = rows[i].ext;
      repeat (3) @(negedge clk_sys_i);
      op(mk(rows[i].k, rows[i].a, rows[i].d), rows[i].exp);
    end
    ext_en = '0;
    op(mk(2'd0, 8'h80, 8'h00), 8'h00);
    xm = '{active: 1'b1, data_phase: 1'b0, data_drive: 1'b0, addr: 24'h12_3456, wdata: 8'h9C};
    @(negedge clk_sys_i);
    xm.data_phase = 1'b1;
    xm.data_drive = 1'b1;
    @(negedge clk_sys_i);
    xm.data_drive = 1'b0;
    @(negedge clk_sys_i);
    ext_en = 8'hFF;
    ext_val = 8'h6B;
    repeat (4) @(negedge clk_sys_i);
    chk(xmem_rdata_o, 8'h6B);
    xm = '0;
    ext_en = '0;
    ext_val = 8'hFF;
    op(mk(2'd1, 8'h80, 8'h00), 8'hFF);
    repeat (3) @(negedge clk_sys_i);
    chk(p1_dig, 8'hC3);
    pwm_en = 1'b1;
    pwm_a = 1'b1;
    repeat (4) @(negedge clk_sys_i);
    op(mk(2'd2, 8'hA0, 8'h00), 8'h3A);
    pwm_en = 1'b0;
    spi_en = 1'b1;
    alt = '0;
    repeat (4) @(negedge clk_sys_i);
    // spi owns bits 0..3, zero strobes pull port 3 bits 6,7 and tx low
    op(mk(2'd2, 8'hA0, 8'h00), 8'h5C);
    op(mk(2'd2, 8'hB0, 8'h00), 8'h05);
    chk({7'h00, miso}, 8'h01);
    spi_en = 1'b0;
    rst_i = 1'b1;
    repeat (5) @(negedge clk_sys_i);
    rst_i = 1'b0;
    op(mk(2'd1, 8'hB0, 8'h00), 8'hFF);
    give_verdict();
  end
endmodule // quad_parallel_io_ports_tb
